// ---- rtl/hetc_regs.sv ----
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Trigger mask bit per event, 1 enables
// - Masks banked by the bank selector
// - Bank k maps to events 32k..32k+31
// - Selector ignores writes, reads zero if <=32
// - Selector low n bits, reset zero
// - Bit 7 enables trigger trace id
// - Bit 6 write 1 clears single status
// - Bit 5 shows single trigger fired
// - Bit 4 selects single or multi-shot
// - Bit 2 enables lost-event reporting
// - Bit 1 enables leading zero suppression
// - Tracing needs local and global enable
// - Banked trace mask bit per event
module hetc_regs #(
   parameter int NUM_EVENTS = 64,
   parameter int BANKS      = (NUM_EVENTS + 31) / 32,
   parameter int BSEL_W     = (BANKS > 1) ? $clog2(BANKS) : 1
) (
   input  wire  logic                  i_ref_clk,
   input  wire  logic                  i_rst_b,
   input  wire  logic                  i_clk_en,
   input  wire  logic [7:0]            i_addr,
   input  wire  logic [31:0]           i_wdata,
   input  wire  logic                  i_wr,
   input  wire  logic                  i_rd,
   output logic       [31:0]           o_rdata,
   input  wire  logic                  i_global_en,
   input  wire  logic [3:0]            i_bus_type,
   input  wire  logic [1:0]            i_gtrig_ctl,
   input  wire  logic [NUM_EVENTS-1:0] i_events,
   input  wire  logic                  i_event_lost,
   output logic       [NUM_EVENTS-1:0] o_trace_events,
   output logic                        o_trigger,
   output logic       [6:0]            o_trigger_id,
   output logic                        o_lost_flag,
   output logic                        o_compress,
   output logic                        o_irq
);
   localparam int IRQ_W_L = hetc_pkg::IRQ_W;
   logic                  rst_s1_ff;
   logic                  rst_sync_ff;
   logic [31:0]           trace_mask_ff [BANKS];
   logic [31:0]           trig_mask_ff  [BANKS];
   logic [BSEL_W-1:0]     bank_ff;
   logic                  en_ff;
   logic                  comp_ff;
   logic                  errdet_ff;
   logic                  single_ff;
   logic                  trigid_ff;
   logic                  status_ff;
   logic [IRQ_W_L-1:0]    irq_stat_ff;
   logic [IRQ_W_L-1:0]    irq_en_ff;
   logic [31:0]           rdata_ff;
   logic                  trigger_ff;
   logic                  lost_ff;

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rst_s1_ff   <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_s1_ff   <= 1'b1;
         rst_sync_ff <= rst_s1_ff;
      end
   end

   wire rst_n = rst_sync_ff;
   wire sel_mask  = (i_addr == hetc_pkg::OFF_TRACE_MASK);
   wire sel_trig  = (i_addr == hetc_pkg::OFF_TRIGGER_MASK);
   wire sel_bank  = (i_addr == hetc_pkg::OFF_BANK_SEL);
   wire sel_ctrl  = (i_addr == hetc_pkg::OFF_MAIN_CTRL);
   wire sel_istat = (i_addr == hetc_pkg::OFF_IRQ_STATUS);
   wire sel_ien   = (i_addr == hetc_pkg::OFF_IRQ_ENABLE);
   wire sel_iclr  = (i_addr == hetc_pkg::OFF_IRQ_CLEAR);
   wire wr_ctrl   = i_clk_en && i_wr && sel_ctrl;
   wire has_banks = (BANKS > 1);
   wire has_trigid = (i_bus_type == hetc_pkg::BUS_TYPE_TRIGID);
   wire has_mode   = (i_gtrig_ctl == hetc_pkg::GTRIG_MODE_OK);
   wire active     = en_ff && i_global_en;
   wire single     = has_mode && single_ff;
   wire [BSEL_W-1:0] bank = has_banks ? bank_ff : '0;

   // Per-bank masks and event gating
   genvar g;
   logic [BANKS-1:0] bank_trig_hit;
   generate
      for (g = 0; g < BANKS; g++) begin : g_bank
         localparam int LO = g * 32;
         localparam int HI = (LO + 32 > NUM_EVENTS) ? NUM_EVENTS : LO + 32;
         wire bank_hit = (bank == BSEL_W'(g));
         always_ff @(posedge i_ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               trace_mask_ff[g] <= hetc_pkg::MASK_RST;
               trig_mask_ff[g]  <= hetc_pkg::MASK_RST;
            end else if (i_clk_en && i_wr && bank_hit) begin
               if (sel_mask) trace_mask_ff[g] <= i_wdata;
               if (sel_trig) trig_mask_ff[g]  <= i_wdata;
            end
         end
         logic [HI-LO-1:0] trace_ev_ff;
         assign o_trace_events[HI-1:LO] = trace_ev_ff;
         wire [HI-LO-1:0] ev = i_events[HI-1:LO];
         wire [HI-LO-1:0] trace_hit = ev & trace_mask_ff[g][HI-LO-1:0];
         assign bank_trig_hit[g] = |(ev & trig_mask_ff[g][HI-LO-1:0]);
         always_ff @(posedge i_ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               trace_ev_ff <= '0;
            end else if (i_clk_en) begin
               trace_ev_ff <= active ? trace_hit : '0;
            end
         end
         // Trigger mask writes to one bank leave the other banks alone
         property p_bank_own;
            @(posedge i_ref_clk) disable iff (!rst_n)
            (i_clk_en && i_wr && sel_trig && !bank_hit) |=> $stable(trig_mask_ff[g]);
         endproperty
         a_bank_own: assert property (p_bank_own) else $error("other bank written");
      end
   endgenerate

   wire trig_raw  = active && (|bank_trig_hit);
   wire trig_fire = trig_raw && !(single && status_ff);
   wire clr_trig  = wr_ctrl && i_wdata[hetc_pkg::MC_CLEAR] && single;
   wire lost_ev   = active && errdet_ff && i_event_lost;
   wire [IRQ_W_L-1:0] irq_set = {lost_ev, trig_fire};
   wire [IRQ_W_L-1:0] irq_clr = (i_clk_en && i_wr && sel_iclr) ?
                                i_wdata[IRQ_W_L-1:0] : '0;

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bank_ff <= '0;
      end else if (i_clk_en && i_wr && sel_bank && has_banks) begin
         bank_ff <= i_wdata[BSEL_W-1:0];
      end
   end

   // Only implemented control bits are stored
   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         en_ff     <= hetc_pkg::CTRL_RST;
         comp_ff   <= hetc_pkg::CTRL_RST;
         errdet_ff <= hetc_pkg::CTRL_RST;
         single_ff <= hetc_pkg::CTRL_RST;
         trigid_ff <= hetc_pkg::CTRL_RST;
      end else if (wr_ctrl) begin
         en_ff     <= i_wdata[hetc_pkg::MC_EN];
         comp_ff   <= i_wdata[hetc_pkg::MC_COMP];
         errdet_ff <= i_wdata[hetc_pkg::MC_ERRDET];
         single_ff <= i_wdata[hetc_pkg::MC_MODE];
         trigid_ff <= i_wdata[hetc_pkg::MC_TRIGID];
      end
   end

   // Fired status; a new fire wins over a clear
   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_ff <= 1'b0;
      end else if (i_clk_en) begin
         if (trig_fire && single) status_ff <= 1'b1;
         else if (clr_trig) status_ff <= 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         trigger_ff <= 1'b0;
         lost_ff    <= 1'b0;
      end else if (i_clk_en) begin
         trigger_ff <= trig_fire;
         lost_ff    <= lost_ev;
      end
   end

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_ff <= '0;
         irq_en_ff   <= '0;
      end else if (i_clk_en) begin
         irq_stat_ff <= irq_set | (irq_stat_ff & ~irq_clr);
         if (i_wr && sel_ien) irq_en_ff <= i_wdata[IRQ_W_L-1:0];
      end
   end

   wire [31:0] ctrl_rd = {24'h00_0000, has_trigid & trigid_ff, 1'b0,
                          single & status_ff, has_mode & single_ff, 1'b0,
                          errdet_ff, comp_ff, en_ff};
   wire [31:0] rd_mux =
      sel_mask  ? trace_mask_ff[bank] :
      sel_trig  ? trig_mask_ff[bank] :
      sel_bank  ? (has_banks ? 32'(bank_ff) : 32'h0000_0000) :
      sel_ctrl  ? ctrl_rd :
      sel_istat ? 32'(irq_stat_ff) :
      sel_ien   ? 32'(irq_en_ff) : 32'h0000_0000;

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= '0;
      end else if (i_clk_en) begin
         rdata_ff <= i_rd ? rd_mux : 32'h0000_0000;
      end
   end

   assign o_rdata      = rdata_ff;
   assign o_trigger    = trigger_ff;
   assign o_trigger_id = (has_trigid && trigid_ff) ? hetc_pkg::TRIG_TRACE_ID : 7'h00;
   assign o_lost_flag  = lost_ff;
   assign o_compress   = comp_ff;
   assign o_irq        = |(irq_stat_ff & irq_en_ff);

   property p_single_hold;
      @(posedge i_ref_clk) disable iff (!rst_n)
      (i_clk_en && single && status_ff && !clr_trig) |-> ##1 !trigger_ff;
   endproperty
   a_single_hold: assert property (p_single_hold) else $error("retrigger while held");

   property p_inactive;
      @(posedge i_ref_clk) disable iff (!rst_n)
      (i_clk_en && !active) |=> (o_trace_events == '0 && !trigger_ff);
   endproperty
   a_inactive: assert property (p_inactive) else $error("event passed while off");

   property p_status_set;
      @(posedge i_ref_clk) disable iff (!rst_n)
      (i_clk_en && trig_fire && single) |=> status_ff;
   endproperty
   a_status_set: assert property (p_status_set) else $error("status not set");

   property p_clear;
      @(posedge i_ref_clk) disable iff (!rst_n)
      (clr_trig && !trig_fire) |=> !status_ff;
   endproperty
   a_clear: assert property (p_clear) else $error("clear ignored");

   property p_bank_zero;
      @(posedge i_ref_clk) disable iff (!rst_n)
      (i_clk_en && i_rd && sel_bank && !has_banks) |=> (o_rdata == 32'h0000_0000);
   endproperty
   a_bank_zero: assert property (p_bank_zero) else $error("bank select not zero");

   property p_lost;
      @(posedge i_ref_clk) disable iff (!rst_n)
      (i_clk_en && !errdet_ff) |=> !o_lost_flag;
   endproperty
   a_lost: assert property (p_lost) else $error("loss without detect");

   property p_ctrl_rd;
      @(posedge i_ref_clk) disable iff (!rst_n)
      (i_clk_en && i_rd && sel_ctrl) |=> (o_rdata[0] == $past(en_ff) && o_rdata[1] == $past(comp_ff));
   endproperty
   a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback wrong");

   property p_trig_rd;
      @(posedge i_ref_clk) disable iff (!rst_n)
      (i_clk_en && i_wr && sel_trig) ##1 (i_clk_en && i_rd && sel_trig && !i_wr && $stable(bank))
      |=> (o_rdata == $past(i_wdata, 2));
   endproperty
   a_trig_rd: assert property (p_trig_rd) else $error("trigger mask lost");

   property p_bank_inert;
      @(posedge i_ref_clk) disable iff (!rst_n)
      (i_clk_en && i_wr && sel_bank && !has_banks) |=> $stable(bank_ff);
   endproperty
   a_bank_inert: assert property (p_bank_inert) else $error("bank select written");

   property p_bank_wr;
      @(posedge i_ref_clk) disable iff (!rst_n)
      (i_clk_en && i_wr && sel_bank && has_banks) |=> (bank_ff == $past(i_wdata[BSEL_W-1:0]));
   endproperty
   a_bank_wr: assert property (p_bank_wr) else $error("bank select lost");

   property p_mode_absent;
      @(posedge i_ref_clk) disable iff (!rst_n)
      (i_clk_en && i_rd && sel_ctrl && !has_mode) |=> !o_rdata[hetc_pkg::MC_MODE];
   endproperty
   a_mode_absent: assert property (p_mode_absent) else $error("mode without feature");

   property p_status_multi;
      @(posedge i_ref_clk) disable iff (!rst_n)
      (i_clk_en && i_rd && sel_ctrl && !single) |=> !o_rdata[hetc_pkg::MC_STAT];
   endproperty
   a_status_multi: assert property (p_status_multi) else $error("multi-shot status");

   property p_compress;
      @(posedge i_ref_clk) disable iff (!rst_n)
      wr_ctrl |=> (o_compress == $past(i_wdata[hetc_pkg::MC_COMP]));
   endproperty
   a_compress: assert property (p_compress) else $error("compression bit lost");

   property p_lost_on;
      @(posedge i_ref_clk) disable iff (!rst_n)
      (i_clk_en && active && errdet_ff && i_event_lost) |=> o_lost_flag;
   endproperty
   a_lost_on: assert property (p_lost_on) else $error("loss not reported");

   // Clock enable low freezes the control state
   property p_frozen;
      @(posedge i_ref_clk) disable iff (!rst_n)
      (!i_clk_en) |=> ($stable(en_ff) && $stable(bank_ff) && $stable(status_ff));
   endproperty
   a_frozen: assert property (p_frozen) else $error("state moved while frozen");
endmodule
`default_nettype wire

// ---- shared/hetc_pkg.sv ----
`default_nettype none
package hetc_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_TRACE_MASK   = 8'h00;
   localparam logic [7:0] OFF_TRIGGER_MASK = 8'h20;
   localparam logic [7:0] OFF_BANK_SEL     = 8'h60;
   localparam logic [7:0] OFF_MAIN_CTRL    = 8'h64;
   localparam logic [7:0] OFF_IRQ_STATUS   = 8'h80;
   localparam logic [7:0] OFF_IRQ_ENABLE   = 8'h84;
   localparam logic [7:0] OFF_IRQ_CLEAR    = 8'h88;
   // Main control field positions
   localparam int MC_EN     = 0;
   localparam int MC_COMP   = 1;
   localparam int MC_ERRDET = 2;
   localparam int MC_MODE   = 4;
   localparam int MC_STAT   = 5;
   localparam int MC_CLEAR  = 6;
   localparam int MC_TRIGID = 7;
   // Interrupt status bits
   localparam int IRQ_TRIG = 0;
   localparam int IRQ_LOST = 1;
   localparam int IRQ_W    = 2;
   // Reset values
   localparam logic [31:0] MASK_RST = 32'h0000_0000;
   localparam logic        CTRL_RST = 1'b0;
   // Feature encodings, trace id
   localparam logic [3:0] BUS_TYPE_TRIGID = 4'h1;
   localparam logic [1:0] GTRIG_MODE_OK   = 2'h2;
   localparam logic [6:0] TRIG_TRACE_ID   = 7'h7d;
endpackage
`default_nettype wire

// ---- tb/tb_hw_event_trace_trigger_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_hw_event_trace_trigger_control;
   logic        clk, rst_b, clk_en, wr, rd, gen, lost, trig, lost_flag, comp, irq;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, rdata_s, rd_v, rd_s, m0, m1;
   logic [3:0]  bus_type;
   logic [1:0]  gtrig;
   logic [63:0] ev, trace_ev;
   logic [6:0]  trig_id;
   int          err_count, checks_done, trig_cnt, lost_cnt;

   hetc_regs #(.NUM_EVENTS(64)) dut (
      .i_ref_clk(clk), .i_rst_b(rst_b), .i_clk_en(clk_en), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_global_en(gen), .i_bus_type(bus_type),
      .i_gtrig_ctl(gtrig), .i_events(ev), .i_event_lost(lost), .o_trace_events(trace_ev),
      .o_trigger(trig), .o_trigger_id(trig_id), .o_lost_flag(lost_flag),
      .o_compress(comp), .o_irq(irq));
   // Single-bank build, selector must stay inert
   hetc_regs #(.NUM_EVENTS(32)) dut_small (
      .i_ref_clk(clk), .i_rst_b(rst_b), .i_clk_en(clk_en), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata_s), .i_global_en(gen), .i_bus_type(bus_type),
      .i_gtrig_ctl(gtrig), .i_events(ev[31:0]), .i_event_lost(lost), .o_trace_events(),
      .o_trigger(), .o_trigger_id(), .o_lost_flag(), .o_compress(), .o_irq());

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      if (trig === 1'b1) trig_cnt++;
      if (lost_flag === 1'b1) lost_cnt++;
   end

   function automatic logic [63:0] exp_trace(input logic [63:0] e, input logic [31:0] a,
                                             input logic [31:0] b, input logic on);
      return on ? (e & {b, a}) : 64'h0;
   endfunction

   task automatic check(input string what, input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask

   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      rd_v = rdata;
      rd_s = rdata_s;
   endtask

   task automatic pulse(input logic [63:0] e, input logic l);
      @(posedge clk);
      ev   <= e;
      lost <= l;
      @(posedge clk);
      ev   <= 64'h0;
      lost <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      #100000;
      err_count++;
      tally_and_finish();
   end

   initial begin
      {rst_b, wr, rd, lost, addr, wdata, bus_type, gtrig, ev} = '0;
      {clk_en, gen} = 2'b11;
      m0 = $urandom(32'h5a0b);
      m1 = $urandom;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      rd_reg(8'h60);
      check("bank_rst", rd_v[0], 1'b0);
      rd_reg(8'h64);
      check("en_rst", rd_v[0], 1'b0);
      $display("reset test done");
      // Both banks filled before enabling
      wr_reg(8'h60, 32'h0);
      wr_reg(8'h00, m0);
      wr_reg(8'h20, 32'h1);
      wr_reg(8'h60, 32'h1);
      rd_reg(8'h60);
      check("bank_sel", rd_v[0], 1'b1);
      check("bank_small", rd_s, 32'h0);
      wr_reg(8'h00, m1);
      wr_reg(8'h20, 32'h0);
      rd_reg(8'h00);
      check("trace_b1", rd_v, m1);
      rd_reg(8'h20);
      check("trig_b1", rd_v, 32'h0);
      wr_reg(8'h60, 32'hffff_fffe);
      rd_reg(8'h00);
      check("trace_b0", rd_v, m0);
      rd_reg(8'h20);
      check("trig_b0", rd_v, 32'h1);
      $display("bank test done");
      wr_reg(8'h64, 32'h1);
      repeat (4) begin
         @(posedge clk);
         ev <= {$urandom, $urandom};
         @(posedge clk);
         #1;
         check("trace_ev", trace_ev, exp_trace(ev, m0, m1, 1'b1));
      end
      @(posedge clk);
      gen <= 1'b0;
      @(posedge clk);
      #1;
      check("trace_off", trace_ev, exp_trace(ev, m0, m1, 1'b0));
      @(posedge clk);
      ev  <= 64'h0;
      gen <= 1'b1;
      $display("trace test done");
      gtrig <= 2'h2;
      wr_reg(8'h64, 32'h51);
      rd_reg(8'h64);
      check("mode_stat", rd_v[5:4], 2'b01);
      trig_cnt = 0;
      pulse(64'h1_0000_0000, 1'b0);
      check("trig_b1ev", trig_cnt, 0);
      pulse(64'h1, 1'b0);
      check("trig_one", trig_cnt, 1);
      rd_reg(8'h64);
      check("stat_set", rd_v[5], 1'b1);
      pulse(64'h1, 1'b0);
      check("trig_hold", trig_cnt, 1);
      wr_reg(8'h64, 32'h51);
      rd_reg(8'h64);
      check("stat_clr", rd_v[5], 1'b0);
      pulse(64'h1, 1'b0);
      check("trig_again", trig_cnt, 2);
      // Clear bit never written in multi-shot
      wr_reg(8'h64, 32'h01);
      pulse(64'h1, 1'b0);
      pulse(64'h1, 1'b0);
      check("trig_multi", trig_cnt, 4);
      $display("trigger test done");
      bus_type <= 4'h1;
      wr_reg(8'h64, 32'h87);
      rd_reg(8'h64);
      check("id_bit", rd_v[7], 1'b1);
      check("trig_id", trig_id, 7'h7d);
      check("comp_on", comp, 1'b1);
      lost_cnt = 0;
      pulse(64'h0, 1'b1);
      check("lost_on", lost_cnt, 1);
      wr_reg(8'h64, 32'hffff_ff09);
      rd_reg(8'h64);
      check("comp_off", comp, 1'b0);
      check("id_off", trig_id, 7'h0);
      pulse(64'h0, 1'b1);
      check("lost_off", lost_cnt, 1);
      $display("control test done");
      wr_reg(8'h88, 32'h3);
      wr_reg(8'h84, 32'h1);
      pulse(64'h1, 1'b0);
      check("irq_on", irq, 1'b1);
      rd_reg(8'h80);
      check("irq_stat", rd_v[0], 1'b1);
      wr_reg(8'h88, 32'h1);
      rd_reg(8'h40);
      check("unmapped", rd_v, 32'h0);
      check("irq_clr", irq, 1'b0);
      wr_reg(8'h84, 32'h0);
      pulse(64'h1, 1'b0);
      check("irq_mask", irq, 1'b0);
      $display("interrupt test done");
      // Reset in mid-run must restore selector and enable
      wr_reg(8'h60, 32'h1);
      wr_reg(8'h64, 32'h3);
      @(posedge clk);
      rst_b <= 1'b0;
      @(posedge clk);
      #1;
      check("rst_comp", comp, 1'b0);
      @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      rd_reg(8'h60);
      check("rst_bank", rd_v[0], 1'b0);
      rd_reg(8'h64);
      check("rst_en", rd_v[0], 1'b0);
      // Write with the clock enable low must not land
      @(posedge clk);
      clk_en <= 1'b0;
      wr_reg(8'h64, 32'h1);
      @(posedge clk);
      clk_en <= 1'b1;
      rd_reg(8'h64);
      check("frozen_en", rd_v[0], 1'b0);
      // Back-to-back write then read of the trigger mask
      @(posedge clk);
      addr  <= 8'h20;
      wdata <= m1;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check("b2b_trig", rdata, m1);
      $display("corner test done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
